// file: design/cgr_regs.sv
// codec gain ramp, boost, click guard and bypass route registers on classic wishbone
module cgr_regs #(
   parameter int RAMP0_CYC = cgr_pkg::RAMP0_CYC,
   parameter int RAMP1_CYC = cgr_pkg::RAMP1_CYC,
   parameter int RAMP2_CYC = cgr_pkg::RAMP2_CYC
) (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             reset_n_i,
   // wishbone slave
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [7:0]       wb_adr_i,
   input  wire logic [3:0]       wb_sel_i,
   input  wire logic [31:0]      wb_dat_i,
   output logic      [31:0]      wb_dat_o,
   output logic                  wb_ack_o,
   // settings from the amplifier gain and dac volume registers
   input  wire logic [3:0][5:0]  amp_gain_code_i,
   input  wire logic [7:0]       dac0_volume_i,
   input  wire logic [7:0]       dac1_volume_i,
   // amplifier gain, quarter-dB units above -12 dB
   output logic      [3:0][7:0]  amp_gain_eff_o,
   output logic      [3:0]       amp_ramping_o,
   // click guard enables
   output logic      [3:0]       click_guard_on_in_o,
   output logic      [1:0]       click_guard_on_out_o,
   // converter path
   output logic      [1:0]       bypass_route_o,
   output logic      [7:0]       dac0_volume_o,
   output logic      [7:0]       dac1_volume_o
);

   ////////////////////////////////////////////////////////////////////////////
   // step period for one quarter-dB move
   localparam int STEP0_RAW = RAMP0_CYC / cgr_pkg::RAMP_STEPS;
   localparam int STEP1_RAW = RAMP1_CYC / cgr_pkg::RAMP_STEPS;
   localparam int STEP2_RAW = RAMP2_CYC / cgr_pkg::RAMP_STEPS;
   localparam logic [cgr_pkg::TICK_W-1:0] STEP0 =
      cgr_pkg::TICK_W'((STEP0_RAW < 1) ? 1 : STEP0_RAW);
   localparam logic [cgr_pkg::TICK_W-1:0] STEP1 =
      cgr_pkg::TICK_W'((STEP1_RAW < 1) ? 1 : STEP1_RAW);
   localparam logic [cgr_pkg::TICK_W-1:0] STEP2 =
      cgr_pkg::TICK_W'((STEP2_RAW < 1) ? 1 : STEP2_RAW);

   typedef struct packed {
      logic [7:0]                  ramp;
      logic [7:0]                  boost;
      logic [7:0]                  charge;
      logic [7:0]                  route;
      logic [7:0]                  lvl0;
      logic [7:0]                  lvl1;
      logic [cgr_pkg::TICK_W-1:0]  tick_cnt;
      logic [3:0][7:0]             gain;
      logic [3:0]                  busy;
      logic [3:0]                  grd_in;
      logic [1:0]                  grd_out;
      logic [1:0]                  path;
      logic [7:0]                  vol0;
      logic [7:0]                  vol1;
      logic                        ack;
      logic [31:0]                 rdat;
   } cgr_state_s;

   cgr_state_s q;
   cgr_state_s d;
   logic [1:0] rst_sync_q;
   logic       rst_n;

   ////////////////////////////////////////////////////////////////////////////
   // functions

   // base code and boost into quarter-dB units above -12 dB
   function automatic logic [7:0] cgr_target(input logic [5:0] code, input logic boost);
      logic [7:0] base;
      base = 8'(code) * cgr_pkg::QDB_PER_CODE;
      if (boost)
      begin
         return base + cgr_pkg::QDB_BOOST;
      end
      return base;
   endfunction

   // ramp-time code into cycles per step
   function automatic logic [cgr_pkg::TICK_W-1:0] cgr_step(input logic [1:0] rate);
      case (rate)
         cgr_pkg::RATE_SHORT: return STEP0;
         cgr_pkg::RATE_MID:   return STEP1;
         default:             return STEP2;
      endcase
   endfunction

   // register read-back, reserved bits already zero in storage
   function automatic logic [7:0] cgr_read(input cgr_state_s s, input logic [5:0] idx);
      case (idx)
         cgr_pkg::IDX_RAMP:   return s.ramp;
         cgr_pkg::IDX_BOOST:  return s.boost;
         cgr_pkg::IDX_CHARGE: return s.charge;
         cgr_pkg::IDX_ROUTE:  return s.route;
         cgr_pkg::IDX_LVL0:   return s.lvl0;
         cgr_pkg::IDX_LVL1:   return s.lvl1;
         default:             return 8'h00;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // reset release through two flip-flops
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         rst_sync_q <= 2'h0;
      end
      else
      begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_q[1];

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb
   begin
      logic [5:0]                  idx;
      logic [7:0]                  wdat;
      logic [7:0]                  tgt;
      logic                        tick;
      logic [cgr_pkg::TICK_W-1:0]  limit;
      idx   = wb_adr_i[7:2];
      wdat  = wb_dat_i[7:0];
      tgt   = 8'h00;
      tick  = 1'b0;
      limit = cgr_step(q.ramp[cgr_pkg::RATE_LSB +: 2]);
      d     = q;

      // bus: one-cycle ack, write and read data taken at the ack edge
      d.ack = 1'b0;
      if (wb_cyc_i && wb_stb_i && !q.ack)
      begin
         d.ack  = 1'b1;
         d.rdat = {24'h000000, cgr_read(q, idx)};
         if (wb_we_i && wb_sel_i[0])
         begin
            case (idx)
               cgr_pkg::IDX_RAMP:   d.ramp   = wdat & cgr_pkg::MASK_RAMP;
               cgr_pkg::IDX_BOOST:  d.boost  = wdat & cgr_pkg::MASK_BOOST;
               cgr_pkg::IDX_CHARGE: d.charge = wdat & cgr_pkg::MASK_CHARGE;
               cgr_pkg::IDX_ROUTE:  d.route  = wdat & cgr_pkg::MASK_ROUTE;
               cgr_pkg::IDX_LVL0:   d.lvl0   = wdat & cgr_pkg::MASK_LVL;
               cgr_pkg::IDX_LVL1:   d.lvl1   = wdat & cgr_pkg::MASK_LVL;
               default:             d.route  = q.route;
            endcase
         end
      end

      // ramp step timer
      if (q.tick_cnt >= limit - 1'b1)
      begin
         d.tick_cnt = '0;
         tick       = 1'b1;
      end
      else
      begin
         d.tick_cnt = q.tick_cnt + 1'b1;
      end

      // per-amplifier gain move toward its target
      for (int k = 0; k < 4; k++)
      begin
         tgt = cgr_target(amp_gain_code_i[k], q.boost[k]);
         if (q.ramp[k])
         begin
            d.gain[k] = tgt;
         end
         else if (tick && (q.gain[k] < tgt))
         begin
            d.gain[k] = q.gain[k] + 1'b1;
         end
         else if (tick && (q.gain[k] > tgt))
         begin
            d.gain[k] = q.gain[k] - 1'b1;
         end
         d.busy[k] = (d.gain[k] != tgt);
      end

      // click guards are on while the disable bit is clear
      d.grd_in  = ~q.charge[3:0];
      d.grd_out = ~q.charge[cgr_pkg::OUT_GRD_LSB +: 2];

      // converter path and volume selection
      d.path = q.route[1:0];
      d.vol0 = q.route[0] ? q.lvl0 : dac0_volume_i;
      d.vol1 = q.route[1] ? q.lvl1 : dac1_volume_i;
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q          <= '0;
         q.ramp     <= cgr_pkg::RST_RAMP;
         q.boost    <= cgr_pkg::RST_BOOST;
         q.charge   <= cgr_pkg::RST_CHARGE;
         q.route    <= cgr_pkg::RST_ROUTE;
         q.lvl0     <= cgr_pkg::RST_LVL;
         q.lvl1     <= cgr_pkg::RST_LVL;
      end
      else
      begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign wb_dat_o             = q.rdat;
   assign wb_ack_o             = q.ack;
   assign amp_gain_eff_o       = q.gain;
   assign amp_ramping_o        = q.busy;
   assign click_guard_on_in_o  = q.grd_in;
   assign click_guard_on_out_o = q.grd_out;
   assign bypass_route_o       = q.path;
   assign dac0_volume_o        = q.vol0;
   assign dac1_volume_o        = q.vol1;

endmodule // cgr_regs

// file: include/cgr_pkg.sv
// constants, field layouts and reset values for the codec gain and route registers
//
// Notes on behaviour
// - ramp-time field [5:4] picks gain-change duration: 21.5, 42.5 or 85 ms
// - ramp-off bit per amplifier makes its gain jump, ignoring the ramp-time field
// - ramp control resets to zero: all amplifiers ramp, shortest time selected
// - boost bit per amplifier adds 10 dB above its programmed gain
// - boost clear: amplifier applies exactly its own gain code, no offset
// - with boost the effective range spans -2 dB to +45.25 dB over the code
// - boost register resets to zero, no extra gain on any amplifier
// - charge bits 5 and 4 switch click guard off on outputs 1 and 0
// - charge bits 3 to 0 switch click guard off on inputs 3 to 0
// - charge register resets to 0x3F, every click guard switched off
// - route field [1:0]: none, ADC0 to DAC0, ADC1 to DAC1, or both
// - during channel 0 bypass its level replaces the normal DAC0 volume
// - during channel 1 bypass its level replaces the normal DAC1 volume
// - route register resets to zero, normal operation without bypass
// - base gain is 6-bit, 0.75 dB per step from -12 dB; boost adds on top
// - bypass levels use DAC volume coding: 0 dB, then 0.375 dB cuts per step
package cgr_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_RAMP   = 6'h27;
   localparam logic [5:0] IDX_BOOST  = 6'h28;
   localparam logic [5:0] IDX_CHARGE = 6'h29;
   localparam logic [5:0] IDX_ROUTE  = 6'h2A;
   localparam logic [5:0] IDX_LVL0   = 6'h2B;
   localparam logic [5:0] IDX_LVL1   = 6'h2C;

   // writable bits of each register
   localparam logic [7:0] MASK_RAMP   = 8'h3F;
   localparam logic [7:0] MASK_BOOST  = 8'h0F;
   localparam logic [7:0] MASK_CHARGE = 8'h3F;
   localparam logic [7:0] MASK_ROUTE  = 8'h03;
   localparam logic [7:0] MASK_LVL    = 8'hFF;

   // reset values
   localparam logic [7:0] RST_RAMP   = 8'h00;
   localparam logic [7:0] RST_BOOST  = 8'h00;
   localparam logic [7:0] RST_CHARGE = 8'h3F;
   localparam logic [7:0] RST_ROUTE  = 8'h00;
   localparam logic [7:0] RST_LVL    = 8'h00;

   // field positions
   localparam int RATE_LSB    = 4;
   localparam int OUT_GRD_LSB = 4;

   // ramp-time codes
   localparam logic [1:0] RATE_SHORT = 2'h0;
   localparam logic [1:0] RATE_MID   = 2'h1;

   // gain arithmetic in quarter-dB units above -12 dB
   localparam logic [7:0] QDB_PER_CODE = 8'h03;
   localparam logic [7:0] QDB_BOOST    = 8'h28;

   ////////////////////////////////////////////////////////////////////////////
   // ramp timing
   localparam real CLK_MHZ    = 100.0;
   localparam real RAMP0_MS   = 21.5;
   localparam real RAMP1_MS   = 42.5;
   localparam real RAMP2_MS   = 85.0;
   localparam int  RAMP0_CYC  = int'(RAMP0_MS * CLK_MHZ * 1000.0);
   localparam int  RAMP1_CYC  = int'(RAMP1_MS * CLK_MHZ * 1000.0);
   localparam int  RAMP2_CYC  = int'(RAMP2_MS * CLK_MHZ * 1000.0);
   // quarter-dB steps across a whole ramp
   localparam int  RAMP_STEPS = 256;
   localparam int  TICK_W     = 24;

endpackage : cgr_pkg

// file: tb/cgr_regs_monitor.sv
// checker of the codec gain and route register outputs
module cgr_regs_monitor (
   input wire logic            clk_i,
   input wire logic            reset_n_i,
   input wire logic            wb_ack_o,
   input wire logic [31:0]     wb_dat_o,
   input wire logic [3:0][7:0] amp_gain_eff_o,
   input wire logic [3:0]      amp_ramping_o,
   input wire logic [3:0]      click_guard_on_in_o,
   input wire logic [1:0]      click_guard_on_out_o,
   input wire logic [1:0]      bypass_route_o,
   input wire logic [7:0]      dac0_volume_i,
   input wire logic [7:0]      dac1_volume_i,
   input wire logic [7:0]      dac0_volume_o,
   input wire logic [7:0]      dac1_volume_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // settle count after reset release, past the two-flop release path
   logic [2:0] up_q;
   logic       up;
   always_ff @(posedge clk_i or negedge reset_n_i)
      if (!reset_n_i)
         up_q <= 3'h0;
      else if (up_q != 3'h7)
         up_q <= up_q + 3'h1;
   assign up = (up_q == 3'h7);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   ////////////////////////////////////////////////////////////////////////////
   a_resv_read_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
      else $error("reserved read bits not zero");
   a_vol0_normal: assert property (up && !bypass_route_o[0] |-> dac0_volume_o == $past(dac0_volume_i))
      else $error("dac0 volume not following normal setting");
   a_vol1_normal: assert property (up && !bypass_route_o[1] |-> dac1_volume_o == $past(dac1_volume_i))
      else $error("dac1 volume not following normal setting");
   a_vol0_bypass_hold: assert property (up && bypass_route_o[0] && $past(bypass_route_o[0])
      && !$past(wb_ack_o) |-> $stable(dac0_volume_o))
      else $error("dac0 bypass volume moved without a write");
   a_route_write_only: assert property (up && !$past(wb_ack_o) |-> $stable(bypass_route_o))
      else $error("route changed without a write");
   a_guard_write_only: assert property (up && !$past(wb_ack_o)
      |-> $stable({click_guard_on_in_o, click_guard_on_out_o}))
      else $error("click guards changed without a write");
   a_ramp_one_step: assert property ($past(amp_ramping_o[0]) && amp_ramping_o[0]
      |-> (amp_gain_eff_o[0] - $past(amp_gain_eff_o[0])) inside {8'h00, 8'h01, 8'hFF})
      else $error("ramping gain jumped");
   a_gain_top: assert property (amp_gain_eff_o[0] <= 8'hE5)
      else $error("gain above boosted top");
   c_bypass_both: cover property (bypass_route_o == 2'h3);
   c_ramping: cover property (amp_ramping_o[0]);
   c_read_data: cover property (wb_ack_o && wb_dat_o[7:0] != 8'h00);
endmodule // cgr_regs_monitor

bind cgr_regs cgr_regs_monitor u_cgr_regs_monitor (.clk_i, .reset_n_i, .wb_ack_o, .wb_dat_o,
   .amp_gain_eff_o, .amp_ramping_o, .click_guard_on_in_o, .click_guard_on_out_o,
   .bypass_route_o, .dac0_volume_i, .dac1_volume_i, .dac0_volume_o, .dac1_volume_o);

// file: tb/testbench.sv
// self-checking bench for the codec gain and route registers
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic            clk_i = 1'b0;
   logic            reset_n_i = 1'b0;
   logic            cyc = 1'b0;
   logic            we = 1'b0;
   logic [7:0]      adr = 8'h00;
   logic [3:0]      sel = 4'h1;
   logic [31:0]     wdat = 32'h0;
   logic [31:0]     rdat;
   logic [31:0]     dat_o;
   logic            ack;
   logic [3:0][5:0] code = '0;
   logic [7:0]      vol0 = 8'h11;
   logic [7:0]      vol1 = 8'h22;
   logic [3:0][7:0] gain;
   logic [3:0]      ramping;
   logic [3:0]      g_in;
   logic [1:0]      g_out;
   logic [1:0]      route;
   logic [7:0]      dv0;
   logic [7:0]      dv1;
   logic [7:0]      ad [6] = '{8'h9C, 8'hA0, 8'hA4, 8'hA8, 8'hAC, 8'hB0};
   logic [7:0]      rst [6] = '{8'h00, 8'h00, 8'h3F, 8'h00, 8'h00, 8'h00};
   logic [7:0]      msk [6] = '{8'h3F, 8'h0F, 8'h3F, 8'h03, 8'hFF, 8'hFF};
   int              miscompares = 0;
   int              total_checks = 0;
   always #5 clk_i = ~clk_i;
   cgr_regs #(.RAMP0_CYC(256), .RAMP1_CYC(512), .RAMP2_CYC(1024)) u_cgr_regs (
      .clk_i, .reset_n_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .amp_gain_code_i(code), .dac0_volume_i(vol0), .dac1_volume_i(vol1),
      .amp_gain_eff_o(gain), .amp_ramping_o(ramping), .click_guard_on_in_o(g_in),
      .click_guard_on_out_o(g_out), .bypass_route_o(route), .dac0_volume_o(dv0),
      .dac1_volume_o(dv1));
   ////////////////////////////////////////////////////////////////////////////
   // one classic cycle, entered right after a rising edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge clk_i);
      while (ack !== 1'b1 && n < 50)
      begin
         @(posedge clk_i);
         n++;
      end
      rdat = dat_o;
      cyc <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e)
      begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(rdat, e);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (5) @(posedge clk_i);
      reset_n_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      for (int i = 0; i < 6; i++)
         rdchk(ad[i], {24'h0, rst[i]});
      chk({g_in, g_out, route}, 32'h0);
      $display("test reset values done");
      for (int i = 0; i < 6; i++)
      begin
         xfer(1'b1, ad[i], 32'hFFFF_FFFF);
         rdchk(ad[i], {24'h0, msk[i]});
      end
      xfer(1'b1, 8'hB4, 32'hFF);
      rdchk(8'hB4, 32'h0);
      $display("test masks done");
      xfer(1'b1, 8'hA4, 32'h15);
      @(posedge clk_i);
      chk({g_out, g_in}, 32'h2A);
      sel <= 4'h0;
      xfer(1'b1, 8'hA4, 32'h00);
      sel <= 4'h1;
      rdchk(8'hA4, 32'h15);
      $display("test click guards done");
      xfer(1'b1, 8'hAC, 32'h5A);
      xfer(1'b1, 8'hB0, 32'hA5);
      for (int r = 0; r < 4; r++)
      begin
         xfer(1'b1, 8'hA8, 32'(r));
         @(posedge clk_i);
         chk({route, dv0, dv1}, {r[1:0], r[0] ? 8'h5A : 8'h11, r[1] ? 8'hA5 : 8'h22});
      end
      $display("test bypass done");
      xfer(1'b1, 8'hA0, 32'h05);
      code <= {6'h05, 6'h00, 6'h10, 6'h3F};
      repeat (3) @(posedge clk_i);
      chk(gain, 32'h0F28_30E5);
      $display("test boost done");
      xfer(1'b1, 8'h9C, 32'h1E);
      xfer(1'b1, 8'hA0, 32'h04);
      repeat (50) @(posedge clk_i);
      chk({ramping[0], gain[0] > 8'hBD}, 32'h3);
      repeat (50) @(posedge clk_i);
      chk({ramping[0], gain[0]}, 32'h0BD);
      $display("test ramp done");
      tally_and_finish();
   end
   initial
   begin
      #200000;
      miscompares++;
      tally_and_finish();
   end
endmodule // testbench
